/* rtl/mts_port.sv */
// Multichannel TDM serial port: transmit channels, frame sync, receive justify
//
// Contract
// - Justify field picks alignment and fill
// - Right aligned negative word fills sign
// - 20-bit words take sign from bit 15
// - Eight blocks of 16 give 128 channels
// - Partition bit one selects fixed 8-partition
// - Word length code 000b means 8 bits
// - Frame length field is slots minus one
// - Frame period field is clocks minus one
// - Ignore bit drops mid-frame frame syncs
// - Each enabled channel raises DMA and interrupt
// - Short 8-partition frames lose later channel 0
// - Without new data, resend previous word
// - Receiver events unaffected by frame length; here rx events stop when the frame closes
// - Each enable bit enables one channel
// - 2-partition: 32 channels, sync starts first
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "mts_map.svh"
module mts_port (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic link_clk,
	input wire logic serial_rx_pin,
	output logic serial_tx_pin,
	output logic serial_tx_oe_b,
	output logic frame_sync_out,
	output logic tx_dma_req,
	output logic rx_dma_req,
	output logic irq
);

	// Word length code to bit count
	function automatic mts_pkg::mts_bits_t word_bits(input logic [2:0] wl);
		case (wl)
			`MTS_WL_8: word_bits = 6'd8;
			`MTS_WL_12: word_bits = 6'd12;
			`MTS_WL_16: word_bits = 6'd16;
			`MTS_WL_20: word_bits = 6'd20;
			`MTS_WL_24: word_bits = 6'd24;
			default: word_bits = 6'd32;
		endcase
	endfunction : word_bits

	// Place a received word in the data registers
	function automatic logic [31:0] justify(input logic [31:0] w, input logic [2:0] wl,
		input logic [1:0] js);
		mts_pkg::mts_bits_t nb;
		logic [31:0] msk;
		logic sgn;
		nb = word_bits(wl);
		msk = (nb == 6'd32) ? 32'hffff_ffff : ((32'h0000_0001 << nb[4:0]) - 32'h0000_0001);
		// Known flaw kept: 20-bit words read the sign from bit 15
		sgn = (wl == `MTS_WL_20) ? w[15] : w[5'(nb - 6'd1)];
		if (js == `MTS_J_RZERO) begin
			justify = w & msk;
		end else if (js == `MTS_J_RSIGN) begin
			justify = sgn ? ((w & msk) | ~msk) : (w & msk);
		end else begin
			justify = (w & msk) << (6'd32 - nb);
		end
	endfunction : justify

	// Software state
	logic ctrl_en_ff;
	logic [1:0] rx_justify_select_ff;
	logic tx_partition_select_ff;
	logic tx_frame_sync_ignore_ff;
	logic [2:0] tx_word_length_ff;
	logic [6:0] tx_frame_length_ff;
	logic [11:0] frame_sync_period_ff;
	logic [31:0] tx_hold_ff;
	logic [31:0] rx_data_ff;
	logic [`MTS_ST_W-1:0] stat_ff;
	logic [`MTS_ST_W-1:0] mask_ff;
	logic [15:0] chan_en_ff [0:7];

	// Link side state
	logic lclk_s1_ff;
	logic lclk_s2_ff;
	logic lclk_s3_ff;
	logic rx_s1_ff;
	logic rx_s2_ff;
	logic [11:0] frame_sync_period_cnt_ff;
	mts_pkg::mts_frame_e frame_ff;
	mts_pkg::mts_slot_t slot_ff;
	logic [4:0] bit_ff;
	logic first_frame_ff;
	logic [31:0] tx_word_ff;
	logic [31:0] rx_shift_ff;

	// Outputs
	logic [31:0] rdata_ff;
	logic tx_pin_ff;
	logic tx_oe_b_ff;
	logic fs_out_ff;
	logic tx_req_ff;
	logic rx_req_ff;
	logic irq_ff;

	logic tick;
	logic fs_pulse;
	logic fs_take;
	logic active_tick;
	mts_pkg::mts_slot_t cur_slot;
	logic [4:0] cur_bit;
	mts_pkg::mts_bits_t nbits;
	logic last_bit;
	logic slot_start;
	logic chan_on;
	logic ch0_drop;
	logic tx_event;
	logic rx_event;
	logic [2:0] blk;
	logic [`MTS_ST_W-1:0] stat_set;
	logic [31:0] rx_word;

	// Link clock crosses in through three flops, the receive pin through two
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			lclk_s1_ff <= 1'b0;
			lclk_s2_ff <= 1'b0;
			lclk_s3_ff <= 1'b0;
			rx_s1_ff <= 1'b0;
			rx_s2_ff <= 1'b0;
		end else if (clk_en) begin
			lclk_s1_ff <= link_clk;
			lclk_s2_ff <= lclk_s1_ff;
			lclk_s3_ff <= lclk_s2_ff;
			rx_s1_ff <= serial_rx_pin;
			rx_s2_ff <= rx_s1_ff;
		end
	end

	// Frame timing decode
	always_comb begin
		tick = lclk_s2_ff & ~lclk_s3_ff & ctrl_en_ff;
		fs_pulse = tick && (frame_sync_period_cnt_ff == 12'h000);
		// A sync inside a frame counts only when not ignored
		fs_take = fs_pulse && (frame_ff == mts_pkg::FR_IDLE || !tx_frame_sync_ignore_ff);
		active_tick = tick && (fs_take || frame_ff == mts_pkg::FR_ACTIVE);
		cur_slot = fs_take ? 7'h00 : slot_ff;
		cur_bit = fs_take ? 5'h00 : bit_ff;
		nbits = word_bits(tx_word_length_ff);
		last_bit = ({1'b0, cur_bit} == nbits - 6'd1);
		slot_start = active_tick && (cur_bit == 5'h00);
	end

	// Channel enable lookup: fixed blocks of 16 in 8-partition mode
	always_comb begin
		blk = tx_partition_select_ff ? cur_slot[6:4] : {2'b00, cur_slot[4]};
		chan_on = chan_en_ff[blk][cur_slot[3:0]];
		// Two partitions reach only channels 0 to 31
		if (!tx_partition_select_ff && cur_slot[6:5] != 2'b00) begin
			chan_on = 1'b0;
		end
		// Flaw kept: short 8-partition frames skip channel 0 after the first frame
		ch0_drop = tx_partition_select_ff && (tx_frame_length_ff < `MTS_FRL_FULL)
			&& (cur_slot == 7'h00) && !first_frame_ff;
		tx_event = slot_start && chan_on && !ch0_drop;
		rx_event = active_tick && last_bit;
		rx_word = {rx_shift_ff[30:0], rx_s2_ff};
	end

	// Sample-rate frame sync generator
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			frame_sync_period_cnt_ff <= 12'h000;
			fs_out_ff <= 1'b0;
		end else if (clk_en) begin
			if (!ctrl_en_ff) begin
				frame_sync_period_cnt_ff <= 12'h000;
				fs_out_ff <= 1'b0;
			end else if (tick) begin
				fs_out_ff <= fs_pulse;
				frame_sync_period_cnt_ff <= fs_pulse ? frame_sync_period_ff : frame_sync_period_cnt_ff - 12'h001;
			end
		end
	end

	// Slot and bit counters
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			frame_ff <= mts_pkg::FR_IDLE;
			slot_ff <= 7'h00;
			bit_ff <= 5'h00;
		end else if (clk_en) begin
			if (!ctrl_en_ff) begin
				frame_ff <= mts_pkg::FR_IDLE;
				slot_ff <= 7'h00;
				bit_ff <= 5'h00;
			end else if (active_tick) begin
				case (frame_ff)
					mts_pkg::FR_IDLE,
					mts_pkg::FR_ACTIVE: begin
						if (last_bit) begin
							bit_ff <= 5'h00;
							slot_ff <= cur_slot + 7'h01;
							// Frame closes after slot count minus one
							frame_ff <= (cur_slot == tx_frame_length_ff) ? mts_pkg::FR_IDLE
								: mts_pkg::FR_ACTIVE;
						end else begin
							bit_ff <= cur_bit + 5'h01;
							frame_ff <= mts_pkg::FR_ACTIVE;
							slot_ff <= cur_slot;
						end
					end
					default: frame_ff <= mts_pkg::FR_IDLE;
				endcase
			end
		end
	end

	// First-frame marker; any later slot 0 opens a new frame, a restarted one too
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			first_frame_ff <= 1'b1;
		end else if (clk_en) begin
			if (!ctrl_en_ff) begin
				first_frame_ff <= 1'b1;
			end else if (slot_start && cur_slot == 7'h00) begin
				first_frame_ff <= 1'b0;
			end
		end
	end

	// Transmit shifter; hold register is reused when software wrote nothing
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tx_word_ff <= 32'h0000_0000;
			tx_pin_ff <= 1'b0;
			tx_oe_b_ff <= 1'b1;
		end else if (clk_en) begin
			if (!ctrl_en_ff) begin
				tx_oe_b_ff <= 1'b1;
			end else if (slot_start) begin
				tx_word_ff <= tx_hold_ff;
				tx_pin_ff <= tx_hold_ff[5'(nbits - 6'd1)];
				tx_oe_b_ff <= !chan_on;
			end else if (active_tick) begin
				tx_pin_ff <= tx_word_ff[5'(nbits - 6'd1 - {1'b0, cur_bit})];
			end else if (tick && frame_ff == mts_pkg::FR_IDLE) begin
				tx_oe_b_ff <= 1'b1;
			end
		end
	end

	// Receive shifter and justified data
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rx_shift_ff <= 32'h0000_0000;
			rx_data_ff <= 32'h0000_0000;
		end else if (clk_en) begin
			if (active_tick) begin
				rx_shift_ff <= rx_word;
			end
			if (rx_event) begin
				rx_data_ff <= justify(rx_word, tx_word_length_ff, rx_justify_select_ff);
			end
		end
	end

	// DMA request pulses
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tx_req_ff <= 1'b0;
			rx_req_ff <= 1'b0;
		end else if (clk_en) begin
			tx_req_ff <= tx_event;
			rx_req_ff <= rx_event;
		end
	end

	// Event sources of the status register
	always_comb begin
		stat_set = '0;
		stat_set[`MTS_ST_TX] = tx_event;
		stat_set[`MTS_ST_RX] = rx_event;
		stat_set[`MTS_ST_FS] = fs_take;
	end

	// Sticky status; a new event beats a same-cycle clear
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			stat_ff <= '0;
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == `MTS_A_STAT) begin
				stat_ff <= (stat_ff & ~reg_wdata[`MTS_ST_W-1:0]) | stat_set;
			end else begin
				stat_ff <= stat_ff | stat_set;
			end
			irq_ff <= |(stat_ff & mask_ff);
		end
	end

	// Register writes
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ctrl_en_ff <= 1'b0;
			rx_justify_select_ff <= `MTS_J_RZERO;
			tx_partition_select_ff <= 1'b0;
			tx_frame_sync_ignore_ff <= 1'b0;
			tx_word_length_ff <= `MTS_WL_8;
			tx_frame_length_ff <= 7'h00;
			frame_sync_period_ff <= 12'h000;
			tx_hold_ff <= 32'h0000_0000;
			mask_ff <= '0;
			for (int i = 0; i < 8; i++) begin
				chan_en_ff[i] <= 16'h0000;
			end
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				`MTS_A_CTRL: begin
					ctrl_en_ff <= reg_wdata[`MTS_CTRL_EN];
					rx_justify_select_ff <= reg_wdata[`MTS_CTRL_JUST_HI:`MTS_CTRL_JUST_LO];
				end
				`MTS_A_TXC: begin
					tx_partition_select_ff <= reg_wdata[`MTS_TXC_PART];
					tx_frame_sync_ignore_ff <= reg_wdata[`MTS_TXC_FIG];
					tx_word_length_ff <= reg_wdata[`MTS_TXC_WL_HI:`MTS_TXC_WL_LO];
					tx_frame_length_ff <= reg_wdata[`MTS_TXC_FRL_HI:`MTS_TXC_FRL_LO];
				end
				`MTS_A_RATE: frame_sync_period_ff <= reg_wdata[`MTS_RATE_HI:0];
				`MTS_A_TXD: tx_hold_ff <= reg_wdata;
				`MTS_A_MASK: mask_ff <= reg_wdata[`MTS_ST_W-1:0];
				default: begin
					if (reg_addr[3]) begin
						chan_en_ff[reg_addr[2:0]] <= reg_wdata[15:0];
					end
				end
			endcase
		end
	end

	// Register reads, answered one cycle later; unmapped reads zero
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rdata_ff <= 32'h0000_0000;
		end else if (clk_en) begin
			rdata_ff <= 32'h0000_0000;
			if (reg_rd) begin
				case (reg_addr)
					`MTS_A_CTRL: rdata_ff <= {29'h0, rx_justify_select_ff, ctrl_en_ff};
					`MTS_A_TXC: rdata_ff <= {20'h0, tx_frame_length_ff, tx_word_length_ff,
						tx_frame_sync_ignore_ff, tx_partition_select_ff};
					`MTS_A_RATE: rdata_ff <= {20'h0, frame_sync_period_ff};
					`MTS_A_TXD: rdata_ff <= tx_hold_ff;
					`MTS_A_RXLO: rdata_ff <= {16'h0, rx_data_ff[15:0]};
					`MTS_A_RXHI: rdata_ff <= {16'h0, rx_data_ff[31:16]};
					`MTS_A_STAT: rdata_ff <= {29'h0, stat_ff};
					`MTS_A_MASK: rdata_ff <= {29'h0, mask_ff};
					default: begin
						if (reg_addr[3]) begin
							rdata_ff <= {16'h0, chan_en_ff[reg_addr[2:0]]};
						end
					end
				endcase
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign serial_tx_pin = tx_pin_ff;
	assign serial_tx_oe_b = tx_oe_b_ff;
	assign frame_sync_out = fs_out_ff;
	assign tx_dma_req = tx_req_ff;
	assign rx_dma_req = rx_req_ff;
	assign irq = irq_ff;

endmodule : mts_port

/* rtl/mts_map.svh */
// Register offsets, field positions and codes of the TDM serial port
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH
// Register indices on the plain register port
`define MTS_A_CTRL 4'h0
`define MTS_A_TXC 4'h1
`define MTS_A_RATE 4'h2
`define MTS_A_TXD 4'h3
`define MTS_A_RXLO 4'h4
`define MTS_A_RXHI 4'h5
`define MTS_A_STAT 4'h6
`define MTS_A_MASK 4'h7
`define MTS_A_EN0 4'h8
// Control fields
`define MTS_CTRL_EN 0
`define MTS_CTRL_JUST_LO 1
`define MTS_CTRL_JUST_HI 2
`define MTS_TXC_PART 0
`define MTS_TXC_FIG 1
`define MTS_TXC_WL_LO 2
`define MTS_TXC_WL_HI 4
`define MTS_TXC_FRL_LO 5
`define MTS_TXC_FRL_HI 11
`define MTS_RATE_HI 11
// Status bits
`define MTS_ST_TX 0
`define MTS_ST_RX 1
`define MTS_ST_FS 2
`define MTS_ST_W 3
// Word length codes
`define MTS_WL_8 3'h0
`define MTS_WL_12 3'h1
`define MTS_WL_16 3'h2
`define MTS_WL_20 3'h3
`define MTS_WL_24 3'h4
// Justify codes
`define MTS_J_RZERO 2'h0
`define MTS_J_RSIGN 2'h1
// Frame length below which channel 0 transmit events drop
`define MTS_FRL_FULL 7'h7f
`endif

/* rtl/mts_pkg.sv */
// Types shared by the TDM serial port
package mts_pkg;
	typedef enum logic {FR_IDLE, FR_ACTIVE} mts_frame_e;
	typedef logic [6:0] mts_slot_t;
	typedef logic [5:0] mts_bits_t;
endpackage : mts_pkg

/* dv/mts_port_properties.sv */
// Port checker of the TDM serial port
`timescale 1ns/1ps
`include "mts_map.svh"
module mts_port_chk (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic serial_tx_pin,
	input wire logic serial_tx_oe_b,
	input wire logic frame_sync_out,
	input wire logic tx_dma_req,
	input wire logic rx_dma_req,
	input wire logic irq
);
	logic en_ff;
	logic [3:0] mask_ff;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// Enable shadow, learnt from bus writes
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			en_ff <= 1'b0;
		end else if (clk_en && reg_wr && reg_addr == `MTS_A_CTRL) begin
			en_ff <= reg_wdata[`MTS_CTRL_EN];
		end
	end
	// Mask shadow; irq may only rise when some bit is open
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			mask_ff <= 4'h0;
		end else if (clk_en && reg_wr && reg_addr == `MTS_A_MASK) begin
			mask_ff <= reg_wdata[3:0];
		end
	end
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
	property p_tx_off;
		!en_ff && !$past(en_ff) |-> !tx_dma_req;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("tx request while disabled");
	property p_tx_pulse;
		tx_dma_req |=> !tx_dma_req;
	endproperty
	a_tx_pulse: assert property (p_tx_pulse) else $error("tx request too long");
	property p_rx_space;
		rx_dma_req |=> !rx_dma_req [*8];
	endproperty
	a_rx_space: assert property (p_rx_space) else $error("rx words too close");
	property p_tx_oe;
		tx_dma_req |-> !serial_tx_oe_b;
	endproperty
	a_tx_oe: assert property (p_tx_oe) else $error("tx request on idle slot");
	property p_irq_mask;
		mask_ff == 4'h0 && $past(mask_ff) == 4'h0 |-> !irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
	property p_fs_width;
		$rose(frame_sync_out) |-> (frame_sync_out || !en_ff) [*3];
	endproperty
	a_fs_width: assert property (p_fs_width) else $error("frame sync too short");
	property p_tx_stable;
		$changed(serial_tx_pin) && en_ff |=> ($stable(serial_tx_pin) || !en_ff) [*3];
	endproperty
	a_tx_stable: assert property (p_tx_stable) else $error("tx bit changed mid tick");
	c_tx: cover property (tx_dma_req);
	c_irq: cover property ($rose(irq));
	c_fs: cover property ($rose(frame_sync_out));
endmodule : mts_port_chk
bind mts_port mts_port_chk u_chk (.*);

/* dv/mts_codec.sv */
// Partner codec model: shift clock and echo of the line
`timescale 1ns/1ps
module mts_codec (
	input wire logic link_run,
	output logic link_clk,
	input wire logic serial_tx_pin,
	input wire logic serial_tx_oe_b,
	output logic serial_rx_pin
);
	// Clock stands low outside streaming; odd offset keeps phase unrelated
	initial begin
		link_clk = 1'b0;
		#37;
		forever begin
			#100;
			link_clk = link_run ? ~link_clk : 1'b0;
		end
	end
	// Undriven line shows the inverse so stale data never passes
	assign serial_rx_pin = serial_tx_oe_b ? ~serial_tx_pin : serial_tx_pin;
endmodule : mts_codec

/* dv/tb_top.sv */
// Top testbench of the TDM serial port
`timescale 1ns/1ps
`include "mts_map.svh"
module tb_top;
	logic core_clk;
	logic rst_b;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic link_clk;
	logic link_run;
	logic rx_pin;
	logic tx_pin;
	logic tx_oe_b;
	logic fs;
	logic tx_dma;
	logic rx_dma;
	logic irq;
	logic clr;
	logic fs_q;
	int n_tx;
	int n_rx;
	int n_fs;
	int error_cnt;
	int n_compared;
	mts_port uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.link_clk(link_clk), .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin),
		.serial_tx_oe_b(tx_oe_b), .frame_sync_out(fs), .tx_dma_req(tx_dma),
		.rx_dma_req(rx_dma), .irq(irq));
	mts_codec peer (.link_run(link_run), .link_clk(link_clk), .serial_tx_pin(tx_pin),
		.serial_tx_oe_b(tx_oe_b), .serial_rx_pin(rx_pin));
	// Core clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Event tallies, cleared while a setup loads
	always @(posedge core_clk) begin
		fs_q <= fs;
		n_tx <= clr ? 0 : n_tx + int'(tx_dma);
		n_rx <= clr ? 0 : n_rx + int'(rx_dma);
		n_fs <= clr ? 0 : n_fs + int'(fs & ~fs_q);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data sampled at the edge closing its only valid cycle
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask : rd
	task automatic go(input logic p, input logic f, input logic [2:0] w, input logic [6:0] l,
		input logic [11:0] q, input logic [1:0] j);
		wr(`MTS_A_CTRL, 32'h0000_0000);
		link_run <= 1'b0;
		wr(`MTS_A_TXC, {20'h0_0000, l, w, f, p});
		wr(`MTS_A_RATE, {20'h0_0000, q});
		clr <= 1'b1;
		wr(`MTS_A_CTRL, {29'h0000_0000, j, 1'b1});
		clr <= 1'b0;
		link_run <= 1'b1;
	endtask : go
	// Loopback shifts the word one bit late, so expect a rotation
	function automatic logic [31:0] exp_rx(input logic [31:0] h, input int n, input logic [1:0] j);
		logic [31:0] m;
		logic [31:0] r;
		m = (32'h0000_0001 << n) - 1;
		r = (((h & m) >> 1) | (h << (n - 1))) & m;
		if (j[1]) return r << (32 - n);
		if (j[0] && ((n == 20) ? r[15] : r[n - 1])) return r | ~m;
		return r;
	endfunction : exp_rx
	task automatic row(input logic p, input logic f, input logic [6:0] l, input logic [11:0] q,
		input int nfs, input int etx, input int erx);
		go(p, f, 3'h0, l, q, 2'h0);
		for (int g = 0; g < 40000 && n_fs < nfs; g++) @(posedge core_clk);
		// A stalled stream counts as a mismatch
		if (n_fs < nfs) error_cnt++;
		chk(32'(n_tx), 32'(etx));
		chk(32'(n_rx), 32'(erx));
	endtask : row
	task automatic close_out();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	// Watchdog well past the longest stream
	initial begin
		#2_000_000;
		error_cnt++;
		close_out();
	end
	initial begin
		logic [31:0] h;
		logic [31:0] lo;
		logic [31:0] hi;
		rst_b = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		clr = 1'b0;
		link_run = 1'b0;
		void'($urandom(33258));
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		chk({31'h0000_0000, tx_oe_b}, 32'h0000_0001);
		rd(`MTS_A_CTRL, lo);
		chk(lo, 32'h0000_0000);
		// Channel 0 of blocks A, C, E, G as in 2-partition mimicry
		for (int b = 0; b < 8; b++) wr(4'(`MTS_A_EN0 + b), b[0] ? 32'h0 : 32'h0000_0001);
		row(1'b1, 1'b0, 7'h03, 12'h01f, 4, 1, 12);
		wr(`MTS_A_CTRL, 32'h0000_0000);
		rd(`MTS_A_STAT, lo);
		chk(lo & 32'h0000_0007, 32'h0000_0007);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		wr(`MTS_A_MASK, 32'h0000_0002);
		repeat (2) @(posedge core_clk);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		wr(`MTS_A_STAT, 32'h0000_000f);
		repeat (2) @(posedge core_clk);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		row(1'b0, 1'b0, 7'h03, 12'h01f, 4, 4, 12);
		row(1'b0, 1'b1, 7'h03, 12'h007, 13, 4, 12);
		row(1'b1, 1'b1, 7'h7f, 12'h0ff, 13, 13, 384);
		// Every word length and justify mode, random words with sign forced
		// Code 5 falls to the 32-bit default length
		for (int c = 0; c < 6; c++) begin
			int n;
			n = (c < 5) ? 8 + 4 * c : 32;
			for (int j = 0; j < 3; j++) begin
				h = ($urandom() | 32'h0000_0001) & 32'hfffe_ffff;
				wr(`MTS_A_TXD, h);
				go(1'b0, 1'b0, c[2:0], 7'h00, 12'(n - 1), j[1:0]);
				for (int g = 0; g < 4000 && n_rx < 3; g++) @(posedge core_clk);
				if (n_rx < 3) error_cnt++;
				rd(`MTS_A_RXLO, lo);
				rd(`MTS_A_RXHI, hi);
				chk({hi[15:0], lo[15:0]}, exp_rx(h, n, j[1:0]));
			end
		end
		close_out();
	end
endmodule : tb_top
